//--- core/smpsc_pkg.sv
// Purpose: Constants and types for the stepper move profiler.
// Assumes: 200 MHz ref_clk, register port with one-cycle read latency.
// Notes:   Offsets are word indices on the plain register port.
package smpsc_pkg;
  // Register offsets
  localparam logic [3:0] SMPSC_REG_CMD     = 4'h0; // Command strobes and control bits
  localparam logic [3:0] SMPSC_REG_TARGET  = 4'h1; // Target position or offset
  localparam logic [3:0] SMPSC_REG_SPEED   = 4'h2; // Programmed speed
  localparam logic [3:0] SMPSC_REG_START   = 4'h3; // Starting speed
  localparam logic [3:0] SMPSC_REG_ACCEL   = 4'h4; // Acceleration per tick
  localparam logic [3:0] SMPSC_REG_DECEL   = 4'h5; // Deceleration per tick
  localparam logic [3:0] SMPSC_REG_JERK    = 4'h6; // Jerk parameter
  localparam logic [3:0] SMPSC_REG_STATUS  = 4'h7; // Status bits
  localparam logic [3:0] SMPSC_REG_POS     = 4'h8; // Motor position
  localparam logic [3:0] SMPSC_REG_PRESET  = 4'h9; // Preset position value
  localparam logic [3:0] SMPSC_REG_ESTOPCF = 4'hA; // Emergency stop input enable
  // Command register bit positions
  localparam int SMPSC_CMD_REL    = 0; // Start relative move
  localparam int SMPSC_CMD_ABS    = 1; // Start absolute move
  localparam int SMPSC_CMD_HOLD   = 2; // Hold (level; rising edge acts)
  localparam int SMPSC_CMD_RESUME = 3; // Resume held move
  localparam int SMPSC_CMD_ISTOP  = 4; // Immediate stop (level; rising edge acts)
  localparam int SMPSC_CMD_RSTERR = 5; // Reset errors
  localparam int SMPSC_CMD_PRESET = 6; // Preset position
  // Status bit positions
  localparam int SMPSC_ST_BUSY    = 0; // Move in progress
  localparam int SMPSC_ST_HELD    = 1; // Hold state
  localparam int SMPSC_ST_PINV    = 2; // Position invalid
  localparam int SMPSC_ST_CMDERR  = 3; // Command error
  localparam int SMPSC_ST_CWLOCK  = 4; // Clockwise moves locked out
  localparam int SMPSC_ST_CCWLOCK = 5; // Counter-clockwise moves locked out
  localparam int SMPSC_ST_ACCEL   = 6; // Ramping up
  localparam int SMPSC_ST_DECEL   = 7; // Ramping down
  // Ranges
  localparam logic signed [31:0] SMPSC_TGT_MAX   = 32'sh007FFFFF; // 8,388,607 counts
  localparam logic signed [31:0] SMPSC_POS_MAX   = 32'sh01F3FFFF; // 32,767,999
  localparam logic signed [31:0] SMPSC_POS_MIN   = -32'sh01F40000; // -32,768,000
  localparam logic [31:0]        SMPSC_START_MAX = 32'h001E847F; // 1,999,999 steps/s
  localparam logic [15:0]        SMPSC_JERK_MAX  = 16'h1388;     // 5,000
  localparam logic [15:0]        SMPSC_JERK_DIV  = 16'h0064;     // 100
  // Timing
  localparam int SMPSC_CLK_HZ     = 200000000; // ref_clk rate
  localparam int SMPSC_TICK_US    = 1;         // Profile update tick in microseconds
  localparam int SMPSC_TICK_CYC   = SMPSC_CLK_HZ / 1000000 * SMPSC_TICK_US; // 200 cycles
  localparam int SMPSC_TICKS_PER_S = 1000000 / SMPSC_TICK_US; // Ticks per second
  // Reset values
  localparam logic [31:0] SMPSC_RST_START = 32'h00000001; // Starting speed after reset
  // Profile phases
  typedef enum logic [2:0] {SMPSC_IDLE, SMPSC_ACC, SMPSC_RUN, SMPSC_DEC, SMPSC_HELD} smpsc_phase_type;
endpackage

//--- core/smpsc_top.sv
// Purpose: One-axis step/direction move profiler with stop, hold and limit handling.
// Assumes: Limit and stop pins are asynchronous, active high; speeds in steps/s.
// Notes:   Speed is an accumulator rate; ramps change speed once per tick.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// RULE1: Jump to start speed, then accelerate
// RULE2: Cruise until remaining equals braking distance
// RULE3: Decelerate, reach start speed at target
// RULE4: Separate acceleration and deceleration rates
// RULE5: Enough steps gives trapezoid with cruise
// RULE6: Too few steps gives triangle profile
// RULE7: Low jerk tapers acceleration early
// RULE8: Controlled stop decelerates, position stays valid
// RULE9: Immediate stop halts pulses, position invalid
// RULE10: Hold stops move; resume or abandon
// RULE11: Host immediate stop kills move
// RULE12: Immediate stop on rising edge only
// RULE13: Limit input during move stops immediately; an opposite-direction limit already active stops only on a new edge
// RULE14: Same-direction limit locks until error reset
// RULE15: Emergency stop edge stops immediately
// RULE16: Relative target is signed offset
// RULE17: Relative moves allowed with invalid position
// RULE18: Held standstill sets hold-state bit
// RULE19: Resume may change rates, keeps target
// RULE20: New move discards held move
// RULE21: Absolute direction from target versus position
// RULE22: Validity from preset only here
// RULE23: Starting speed limited to 1..1,999,999
// RULE24: Jerk zero constant, else S-curve
// RULE25: Position counter range, counts up clockwise
// RULE26: Absolute move while invalid rejected
// RULE27: Rate update per tick, pulse moves position
module smpsc_top
  import smpsc_pkg::*;
#(
  parameter int TICK_CYC = SMPSC_TICK_CYC  // Profile tick length in clocks
) (
  input  wire logic        ref_clk,      // System clock
  input  wire logic        rstn,         // Synchronous reset, active low
  input  wire logic [3:0]  reg_addr,     // Register index
  input  wire logic [31:0] reg_wdata,    // Write data
  input  wire logic        reg_wr,       // Write strobe
  input  wire logic        reg_rd,       // Read strobe
  output logic      [31:0] reg_rdata,    // Read data, cycle after strobe
  input  wire logic        cw_limit,     // Clockwise travel limit pin
  input  wire logic        ccw_limit,    // Counter-clockwise travel limit pin
  input  wire logic        estop_in,     // Emergency stop pin
  output logic             step_out,     // Step pulse
  output logic             dir_cw        // Direction, high for clockwise
);

  // Whole module state
  typedef struct packed {
    logic [2:0]         ps;        // Pin sync stage 1
    logic [2:0]         pin;       // Pin sync stage 2
    logic               estop_old; // Previous emergency stop level
    logic [1:0]         lim_old;   // Previous synchronised limit levels
    logic               istop_old; // Previous immediate stop bit
    logic               hold_old;  // Previous hold bit
    logic [31:0]        rdata;
    logic signed [31:0] target;
    logic [31:0]        speed_cfg;
    logic [31:0]        start_cfg;
    logic [31:0]        acc_cfg;
    logic [31:0]        dec_cfg;
    logic [15:0]        jerk_cfg;
    logic               estop_en;
    logic signed [31:0] preset;
    logic signed [31:0] pos;       // Motor position
    logic [23:0]        remain;    // Steps still to go
    logic signed [31:0] goal;      // Kept target position of current move
    logic [31:0]        spd;       // Present speed
    logic [31:0]        acc_now;   // Present S-curve acceleration
    logic [31:0]        phase_acc; // Step rate accumulator
    logic [15:0]        tick_cnt;
    logic               dir;
    logic               stopping;  // Controlled stop in progress
    logic               hold_req;  // Stop is a hold
    smpsc_phase_type    phase;
    logic               pinv;
    logic               cmderr;
    logic               cwlock;
    logic               ccwlock;
    logic               step;
  } smpsc_state_type;

  smpsc_state_type s_q, s_d;

  // Tick rate follows the tick length, so braking distance stays true with short ticks
  localparam int TICKS_PER_S = SMPSC_CLK_HZ / TICK_CYC;

  // Combinational helpers
  logic        tick;        // One-cycle profile tick
  logic        wr_cmd;      // Command register written
  logic [31:0] brake;       // Steps needed to slow to start speed
  logic [31:0] jerk_step;   // Acceleration change per tick
  logic [32:0] acc_sum;     // Step accumulator sum
  logic        istop;       // Any immediate stop cause

  assign tick   = (s_q.tick_cnt == 16'(TICK_CYC - 1));
  assign wr_cmd = reg_wr && (reg_addr == SMPSC_REG_CMD);
  // Braking distance: (v^2 - v0^2) / (2 d) in steps, tick-scaled  [RULE2]
  assign brake  = (s_q.dec_cfg == 32'h0) ? 32'h0 :
                  32'((64'(s_q.spd - s_q.start_cfg) * 64'(s_q.spd + s_q.start_cfg)) /
                  (64'(s_q.dec_cfg) * 64'(2 * TICKS_PER_S)));
  assign jerk_step = 32'((64'(s_q.acc_cfg) * 64'(s_q.jerk_cfg)) / 64'(SMPSC_JERK_DIV)); // [RULE24]
  assign acc_sum = 33'(s_q.phase_acc) + 33'(s_q.spd);

  // Next-state logic
  always_comb begin
    s_d       = s_q;
    s_d.step  = 1'b0;
    s_d.ps    = {estop_in, ccw_limit, cw_limit};
    s_d.pin   = s_q.ps;
    s_d.rdata = 32'h0;
    s_d.tick_cnt = tick ? 16'h0 : s_q.tick_cnt + 16'h1;
    s_d.estop_old = s_q.pin[2];
    s_d.lim_old   = s_q.pin[1:0];
    // Immediate stop causes, edge triggered  [RULE12] [RULE15]
    istop = (wr_cmd && reg_wdata[SMPSC_CMD_ISTOP] && !s_q.istop_old) ||
            (s_q.estop_en && s_q.pin[2] && !s_q.estop_old);
    if (wr_cmd) begin
      s_d.istop_old = reg_wdata[SMPSC_CMD_ISTOP];
      s_d.hold_old  = reg_wdata[SMPSC_CMD_HOLD];
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        SMPSC_REG_TARGET:  s_d.target    = reg_wdata;
        SMPSC_REG_SPEED:   s_d.speed_cfg = reg_wdata;
        // Starting speed clamped to its legal range  [RULE23]
        SMPSC_REG_START:   s_d.start_cfg = (reg_wdata == 32'h0) ? 32'h1 :
                                           (reg_wdata > SMPSC_START_MAX) ? SMPSC_START_MAX : reg_wdata;
        SMPSC_REG_ACCEL:   s_d.acc_cfg   = reg_wdata; // [RULE4]
        SMPSC_REG_DECEL:   s_d.dec_cfg   = reg_wdata; // [RULE4]
        SMPSC_REG_JERK:    s_d.jerk_cfg  = (reg_wdata[15:0] > SMPSC_JERK_MAX) ? SMPSC_JERK_MAX : reg_wdata[15:0];
        SMPSC_REG_PRESET:  s_d.preset    = reg_wdata;
        SMPSC_REG_ESTOPCF: s_d.estop_en  = reg_wdata[0];
        default: ;
      endcase
    end
    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        SMPSC_REG_TARGET:  s_d.rdata = s_q.target;
        SMPSC_REG_SPEED:   s_d.rdata = s_q.speed_cfg;
        SMPSC_REG_START:   s_d.rdata = s_q.start_cfg;
        SMPSC_REG_ACCEL:   s_d.rdata = s_q.acc_cfg;
        SMPSC_REG_DECEL:   s_d.rdata = s_q.dec_cfg;
        SMPSC_REG_JERK:    s_d.rdata = {16'h0, s_q.jerk_cfg};
        SMPSC_REG_STATUS:  s_d.rdata = {24'h0, s_q.phase == SMPSC_DEC, s_q.phase == SMPSC_ACC,
                                        s_q.ccwlock, s_q.cwlock, s_q.cmderr, s_q.pinv,
                                        s_q.phase == SMPSC_HELD,
                                        s_q.phase inside {SMPSC_ACC, SMPSC_RUN, SMPSC_DEC}};
        SMPSC_REG_POS:     s_d.rdata = s_q.pos;
        SMPSC_REG_PRESET:  s_d.rdata = s_q.preset;
        SMPSC_REG_ESTOPCF: s_d.rdata = {31'h0, s_q.estop_en};
        default:           s_d.rdata = 32'h0;
      endcase
    end
    // Error reset clears lockouts and command error  [RULE14]
    if (wr_cmd && reg_wdata[SMPSC_CMD_RSTERR]) begin
      s_d.cwlock  = 1'b0;
      s_d.ccwlock = 1'b0;
      s_d.cmderr  = 1'b0;
    end
    // Preset makes position valid  [RULE22]
    if (wr_cmd && reg_wdata[SMPSC_CMD_PRESET] && s_q.phase inside {SMPSC_IDLE, SMPSC_HELD}) begin
      s_d.pos  = s_q.preset;
      s_d.pinv = 1'b0;
    end
    // Step generation from accumulator, one step per overflow  [RULE27]
    if (s_q.phase inside {SMPSC_ACC, SMPSC_RUN, SMPSC_DEC} && s_q.remain != 24'h0) begin
      if (acc_sum >= 33'(SMPSC_CLK_HZ)) begin
        s_d.phase_acc = 32'(acc_sum - 33'(SMPSC_CLK_HZ));
        s_d.step      = 1'b1;
        s_d.remain    = s_q.remain - 24'h1;
        // Clockwise counts up, wrapping at range ends  [RULE25]
        if (s_q.dir) s_d.pos = (s_q.pos == SMPSC_POS_MAX) ? SMPSC_POS_MIN : s_q.pos + 32'sh1;
        else         s_d.pos = (s_q.pos == SMPSC_POS_MIN) ? SMPSC_POS_MAX : s_q.pos - 32'sh1;
      end else begin
        s_d.phase_acc = 32'(acc_sum);
      end
    end
    // Profile update once per tick
    if (tick) begin
      case (s_q.phase)
        SMPSC_ACC: begin
          // Decelerate early if braking distance is reached  [RULE6]
          if (s_q.stopping || 32'(s_q.remain) <= brake) begin
            s_d.phase = SMPSC_DEC;
          end else if (s_q.spd >= s_q.speed_cfg) begin
            s_d.spd   = s_q.speed_cfg;
            s_d.phase = SMPSC_RUN; // [RULE5]
          end else if (s_q.jerk_cfg == 16'h0) begin
            s_d.spd = s_q.spd + s_q.acc_cfg; // [RULE1] [RULE24]
          end else begin
            // S-curve: ramp acceleration, taper it near the speed  [RULE7]
            if (s_q.speed_cfg - s_q.spd <= s_q.acc_now) begin
              s_d.acc_now = (s_q.acc_now > jerk_step) ? s_q.acc_now - jerk_step : 32'h1;
            end else if (s_q.acc_now < s_q.acc_cfg) begin
              s_d.acc_now = (s_q.acc_now + jerk_step > s_q.acc_cfg) ? s_q.acc_cfg : s_q.acc_now + jerk_step;
            end
            s_d.spd = s_q.spd + s_q.acc_now;
          end
        end
        SMPSC_RUN: begin
          // Cruise until braking point or stop  [RULE2] [RULE8]
          if (s_q.stopping || 32'(s_q.remain) <= brake) s_d.phase = SMPSC_DEC;
        end
        SMPSC_DEC: begin
          // Slow at deceleration rate, floor at start speed  [RULE3] [RULE8]
          s_d.spd = (s_q.spd > s_q.start_cfg + s_q.dec_cfg) ? s_q.spd - s_q.dec_cfg : s_q.start_cfg;
          if (s_q.stopping && s_q.spd == s_q.start_cfg) begin
            s_d.phase = s_q.hold_req ? SMPSC_HELD : SMPSC_IDLE; // [RULE18]
          end
        end
        default: ;
      endcase
    end
    // Move end at target position  [RULE3]
    if (s_q.phase inside {SMPSC_ACC, SMPSC_RUN, SMPSC_DEC} && s_q.remain == 24'h0) begin
      s_d.phase = SMPSC_IDLE;
    end
    // Hold on rising edge of hold bit  [RULE10]
    if (wr_cmd && reg_wdata[SMPSC_CMD_HOLD] && !s_q.hold_old &&
        s_q.phase inside {SMPSC_ACC, SMPSC_RUN, SMPSC_DEC}) begin
      s_d.stopping = 1'b1;
      s_d.hold_req = 1'b1;
    end
    // Resume keeps the goal, takes new rates from registers  [RULE19]
    if (wr_cmd && reg_wdata[SMPSC_CMD_RESUME] && s_q.phase == SMPSC_HELD) begin
      s_d.phase    = SMPSC_ACC;
      s_d.spd      = s_q.start_cfg;
      s_d.acc_now  = jerk_step;
      s_d.stopping = 1'b0;
      s_d.hold_req = 1'b0;
    end
    // New move start; discards any held move  [RULE20]
    if (wr_cmd && (reg_wdata[SMPSC_CMD_REL] || reg_wdata[SMPSC_CMD_ABS]) &&
        s_q.phase inside {SMPSC_IDLE, SMPSC_HELD}) begin
      s_d.phase    = SMPSC_IDLE;
      s_d.stopping = 1'b0;
      s_d.hold_req = 1'b0;
      if (reg_wdata[SMPSC_CMD_ABS] && s_q.pinv) begin
        s_d.cmderr = 1'b1; // [RULE26]
      end else begin
        if (reg_wdata[SMPSC_CMD_REL]) begin
          // Signed offset, sign sets direction  [RULE16] [RULE17]
          s_d.dir    = !s_q.target[31];
          s_d.remain = 24'(s_q.target[31] ? -s_q.target : s_q.target);
          s_d.goal   = s_q.pos + s_q.target;
        end else begin
          // Direction from target against position  [RULE21]
          s_d.dir    = (s_q.target > s_q.pos);
          s_d.remain = 24'((s_q.target > s_q.pos) ? s_q.target - s_q.pos : s_q.pos - s_q.target);
          s_d.goal   = s_q.target;
        end
        // Out of range target or locked direction refused  [RULE14]
        if (s_q.target > SMPSC_TGT_MAX || s_q.target < -SMPSC_TGT_MAX ||
            (s_d.dir && s_q.cwlock) || (!s_d.dir && s_q.ccwlock)) begin
          s_d.cmderr = 1'b1;
          s_d.remain = 24'h0;
        end else if (s_d.remain != 24'h0) begin
          s_d.phase     = SMPSC_ACC;
          s_d.spd       = s_q.start_cfg; // [RULE1]
          s_d.acc_now   = jerk_step;
          s_d.phase_acc = 32'h0;
        end
      end
    end
    // Resume distance recomputed from kept goal  [RULE19]
    if (wr_cmd && reg_wdata[SMPSC_CMD_RESUME] && s_q.phase == SMPSC_HELD) begin
      s_d.remain = 24'(s_q.goal > s_q.pos ? s_q.goal - s_q.pos : s_q.pos - s_q.goal);
    end
    // Limit hit while moving: immediate stop, same-direction lock  [RULE13] [RULE14]
    // Opposite limit acts only on its edge, so a move may leave an active switch
    if (s_q.phase inside {SMPSC_ACC, SMPSC_RUN, SMPSC_DEC} &&
        ((s_q.pin[0] && (s_q.dir || !s_q.lim_old[0])) || (s_q.pin[1] && (!s_q.dir || !s_q.lim_old[1])))) begin
      istop = 1'b1;
      if (s_q.pin[0] && s_q.dir)  s_d.cwlock  = 1'b1;
      if (s_q.pin[1] && !s_q.dir) s_d.ccwlock = 1'b1;
    end
    // Immediate stop wins over everything; move not restartable  [RULE9] [RULE11]
    if (istop) begin
      s_d.phase    = SMPSC_IDLE;
      s_d.step     = 1'b0;
      s_d.remain   = 24'h0;
      s_d.stopping = 1'b0;
      s_d.hold_req = 1'b0;
      s_d.pos      = s_q.pos;
      s_d.pinv     = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q           <= '0;
      s_q.phase     <= SMPSC_IDLE;
      s_q.start_cfg <= SMPSC_RST_START;
      s_q.pinv      <= 1'b1;
      s_q.dir       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign step_out  = s_q.step;
  assign dir_cw    = s_q.dir;

  // Immediate stop command edge marks position invalid next cycle
  AST_ISTOP_PINV: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE9]
    (wr_cmd && reg_wdata[SMPSC_CMD_ISTOP] && !s_q.istop_old) |=> (s_q.pinv && s_q.phase == SMPSC_IDLE))
    else $error("immediate stop did not halt or flag position");
  // Holding the bit high does not retrigger
  AST_ISTOP_EDGE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE12]
    (wr_cmd && reg_wdata[SMPSC_CMD_ISTOP] && s_q.istop_old && s_q.phase == SMPSC_RUN &&
     !s_q.pin[0] && !s_q.pin[1] && !(s_q.estop_en && s_q.pin[2] && !s_q.estop_old) && s_q.remain > 24'h1)
    |=> s_q.phase != SMPSC_IDLE)
    else $error("immediate stop acted on level");
  // No step while idle or held
  AST_NO_STEP_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE27]
    step_out |-> $past(s_q.phase) inside {SMPSC_ACC, SMPSC_RUN, SMPSC_DEC})
    else $error("step while stopped");
  // Clockwise step moves position up by one
  AST_POS_STEP: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE25]
    (step_out && dir_cw && s_q.pos != SMPSC_POS_MIN && $past(s_q.pos) != SMPSC_POS_MAX &&
     !$past(wr_cmd)) |-> s_q.pos == $past(s_q.pos) + 32'sh1)
    else $error("clockwise step did not count up");
  // Absolute move while invalid raises error and stays idle
  AST_ABS_REJECT: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE26]
    (wr_cmd && reg_wdata[SMPSC_CMD_ABS] && !reg_wdata[SMPSC_CMD_REL] && s_q.pinv &&
     s_q.phase == SMPSC_IDLE) |=> (s_q.cmderr && s_q.phase == SMPSC_IDLE) ##1 !step_out)
    else $error("absolute move ran with invalid position");
  // Clockwise limit during a clockwise cruise ends motion next cycle
  AST_LIMIT_STOP: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE13]
    (s_q.phase == SMPSC_RUN && s_q.pin[0] && s_q.dir) |=> (s_q.phase == SMPSC_IDLE && s_q.pinv) ##1 !step_out)
    else $error("limit did not stop the move");
  // Clockwise limit on clockwise move locks clockwise
  AST_LIMIT_LOCK: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
    (s_q.phase == SMPSC_RUN && s_q.pin[0] && s_q.dir && !(wr_cmd && reg_wdata[SMPSC_CMD_RSTERR]))
    |=> s_q.cwlock)
    else $error("same-direction limit did not lock");
  // Start speed stays within range
  AST_START_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE23]
    s_q.start_cfg >= 32'h1 && s_q.start_cfg <= SMPSC_START_MAX)
    else $error("start speed out of range");
  // A new move loads the start speed first
  AST_START_JUMP: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE1]
    ($past(s_q.phase) == SMPSC_IDLE && s_q.phase == SMPSC_ACC) |-> s_q.spd == s_q.start_cfg)
    else $error("move did not begin at start speed");
endmodule

//--- bench/smpsc_host.sv
// Purpose: Host controller model driving the profiler register port.
// Assumes: One strobe per transfer, read data stands the cycle after.
// Notes:   Address shows its inverted last value once released; write data does so only after writes.
`timescale 1ns/10ps
module smpsc_host (
  input  wire logic        ref_clk,   // System clock
  output logic      [3:0]  reg_addr,  // Register index
  output logic      [31:0] reg_wdata, // Write data
  output logic             reg_wr,    // Write strobe
  output logic             reg_rd,    // Read strobe
  input  wire logic [31:0] reg_rdata  // Read data
);
  // Idle bus from time zero
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // One-cycle write; released lines flip so stale data is never trusted
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask
  // One-cycle read, data taken at the rising edge that ends its one standing cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask
endmodule

//--- bench/stepper_move_profile_stop_control_tb.sv
// Purpose: Self-checking bench for the stepper move profiler.
// Assumes: Tick shortened to 4 clocks; host model owns the register port.
// Notes:   Expected position is built from counted step pulses.
`timescale 1ns/10ps
module stepper_move_profile_stop_control_tb;
  import smpsc_pkg::*;
  logic               ref_clk, rstn, reg_wr, reg_rd, step_out, dir_cw; // Port nets
  logic               cw_limit, ccw_limit, estop_in;                   // Pins driven here
  logic        [3:0]  reg_addr;                                         // Register index
  logic        [31:0] reg_wdata, reg_rdata, d;                          // Bus data, last read
  logic signed [31:0] steps, s0, base;                                  // Step tally, snapshot, offset
  int                 error_cnt, checks;                                // Counters
  smpsc_top #(.TICK_CYC(4)) smpsc_top_i (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cw_limit(cw_limit),
    .ccw_limit(ccw_limit), .estop_in(estop_in), .step_out(step_out), .dir_cw(dir_cw));
  smpsc_host smpsc_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Signed step count, clockwise up
  always @(posedge ref_clk) begin
    if (step_out === 1'b1) steps <= (dir_cw === 1'b1) ? steps + 32'sh1 : steps - 32'sh1;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Register read compared with an expected word
  task automatic chk_reg(input string n, input logic [3:0] a, input logic [31:0] exp);
    smpsc_host_i.rd(a, d);
    chk(n, d, exp);
  endtask
  // One status bit compared
  task automatic chk_st(input string n, input int b, input logic exp);
    smpsc_host_i.rd(SMPSC_REG_STATUS, d);
    chk(n, {31'h0, d[b]}, {31'h0, exp});
  endtask
  // Command bit pulsed, then cleared so edge-sensitive bits rearm
  task automatic cmd(input int b);
    smpsc_host_i.wr(SMPSC_REG_CMD, 32'h1 << b);
    smpsc_host_i.wr(SMPSC_REG_CMD, 32'h0);
  endtask
  // Bounded poll of a status bit; the later compare catches a miss
  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 8000; i++) begin
      smpsc_host_i.rd(SMPSC_REG_STATUS, d);
      if (d[b] === v) break;
    end
  endtask
  task automatic rel(input logic [31:0] t);
    smpsc_host_i.wr(SMPSC_REG_TARGET, t);
    cmd(SMPSC_CMD_REL);
  endtask
  // Snapshot steps past pin sync latency, wait, require no further pulses
  task automatic halted(input string n);
    repeat (4) @(posedge ref_clk);
    s0 = steps;
    repeat (400) @(posedge ref_clk);
    chk(n, steps, s0);
  endtask
  task automatic summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial begin
    rstn      = 1'b0;
    cw_limit  = 1'b0;
    ccw_limit = 1'b0;
    estop_in  = 1'b0;
    steps     = 0;
    base      = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    chk_st("pinv reset", SMPSC_ST_PINV, 1'b1);
    chk_reg("start reset", SMPSC_REG_START, 32'h00000001);
    chk_reg("pos reset", SMPSC_REG_POS, 32'h0);
    chk_reg("unmapped", 4'hB, 32'h0);
    smpsc_host_i.wr(SMPSC_REG_START, 32'h000F4240); // Start and peak far apart
    smpsc_host_i.wr(SMPSC_REG_SPEED, 32'h001E847F);
    smpsc_host_i.wr(SMPSC_REG_ACCEL, 32'h0000C350); // Unequal slopes
    smpsc_host_i.wr(SMPSC_REG_DECEL, 32'h00013880);
    smpsc_host_i.wr(SMPSC_REG_TARGET, 32'h5);
    cmd(SMPSC_CMD_ABS); // Absolute while invalid
    chk_st("abs refused", SMPSC_ST_CMDERR, 1'b1);
    halted("abs no steps");
    cmd(SMPSC_CMD_RSTERR);
    rel(32'hA); // Relative with invalid position
    repeat (20) @(posedge ref_clk);
    chk("dir cw", {31'h0, dir_cw}, 32'h1);
    wait_st(SMPSC_ST_BUSY, 1'b0);
    chk("rel steps", steps, 32'hA);
    chk_reg("pos cw", SMPSC_REG_POS, 32'hA);
    rel(32'hFFFFFFFC);
    repeat (20) @(posedge ref_clk);
    chk("dir ccw", {31'h0, dir_cw}, 32'h0);
    wait_st(SMPSC_ST_BUSY, 1'b0);
    chk_reg("pos ccw", SMPSC_REG_POS, 32'h6);
    smpsc_host_i.wr(SMPSC_REG_PRESET, 32'h64);
    cmd(SMPSC_CMD_PRESET);
    chk_st("pinv preset", SMPSC_ST_PINV, 1'b0);
    smpsc_host_i.wr(SMPSC_REG_TARGET, 32'h5A);
    cmd(SMPSC_CMD_ABS);
    repeat (20) @(posedge ref_clk);
    chk("abs dir", {31'h0, dir_cw}, 32'h0);
    wait_st(SMPSC_ST_BUSY, 1'b0);
    chk_reg("abs pos", SMPSC_REG_POS, 32'h5A);
    rel(32'h64);
    repeat (2000) @(posedge ref_clk);
    cmd(SMPSC_CMD_HOLD);
    wait_st(SMPSC_ST_HELD, 1'b1);
    chk_st("held", SMPSC_ST_HELD, 1'b1);
    chk_st("hold pinv", SMPSC_ST_PINV, 1'b0);
    halted("hold still");
    smpsc_host_i.wr(SMPSC_REG_SPEED, 32'h0016E360); // New speed on resume
    cmd(SMPSC_CMD_RESUME);
    wait_st(SMPSC_ST_BUSY, 1'b0);
    chk_reg("resume goal", SMPSC_REG_POS, 32'hBE);
    rel(32'h64);
    repeat (1000) @(posedge ref_clk);
    cmd(SMPSC_CMD_HOLD);
    wait_st(SMPSC_ST_HELD, 1'b1);
    rel(32'hA); // New move from hold
    wait_st(SMPSC_ST_BUSY, 1'b0);
    cmd(SMPSC_CMD_RESUME);
    halted("held dropped");
    rel(32'h1388);
    repeat (1000) @(posedge ref_clk);
    cmd(SMPSC_CMD_ISTOP);
    halted("istop");
    chk_st("istop pinv", SMPSC_ST_PINV, 1'b1);
    cmd(SMPSC_CMD_RESUME);
    halted("no restart");
    rel(32'h1388);
    repeat (1000) @(posedge ref_clk);
    cw_limit <= 1'b1;
    halted("limit stop");
    chk_st("cw lock", SMPSC_ST_CWLOCK, 1'b1);
    rel(32'hA);
    halted("cw refused");
    rel(32'hFFFFFFFD);
    wait_st(SMPSC_ST_BUSY, 1'b0);
    chk("ccw allowed", steps, s0 - 32'sh3);
    cw_limit <= 1'b0;
    cmd(SMPSC_CMD_RSTERR);
    chk_st("lock cleared", SMPSC_ST_CWLOCK, 1'b0);
    smpsc_host_i.wr(SMPSC_REG_JERK, 32'h0000FFFF);
    chk_reg("jerk clamp", SMPSC_REG_JERK, 32'h00001388);
    smpsc_host_i.wr(SMPSC_REG_JERK, 32'h0000000A); // Low jerk
    s0 = steps;
    rel(32'h14);
    wait_st(SMPSC_ST_BUSY, 1'b0);
    chk("s-curve steps", steps, s0 + 32'sh14);
    smpsc_host_i.wr(SMPSC_REG_ESTOPCF, 32'h1);
    rel(32'hFFFFEC78);
    repeat (1000) @(posedge ref_clk);
    estop_in <= 1'b1;
    halted("estop");
    chk_st("estop busy", SMPSC_ST_BUSY, 1'b0);
    summarize();
  end
endmodule
